/* rtl/eeprom_byte_access_ctrl.v */
// cpu-side control of the on-chip data eeprom: address, data, control regs
`timescale 1ns/1ps
`include "nv_access_regs.vh"
module eeprom_byte_access_ctrl (
   input  wire       ref_clk,
   input  wire       rst_n,
   input  wire [5:0] io_addr,
   input  wire       io_wr,
   input  wire       io_rd,
   input  wire [7:0] io_wdata,
   output reg  [7:0] io_rdata,
   input  wire       global_irq_enable,
   input  wire       flash_prog_busy,
   input  wire       rc_osc_tick,
   output wire       cpu_stall,
   output wire       ready_irq,
   output reg  [9:0] mem_addr,
   output reg  [7:0] mem_wdata,
   output reg  [1:0] mem_mode,
   output reg        mem_write,
   output reg        mem_read,
   input  wire [7:0] mem_rdata
);
   parameter WRITE_OSC = `WRITE_OSC_CYCLES;
   localparam [14:0] WRITE_LEN = WRITE_OSC[14:0];

   ////////////////////////////////////////////////////////////////////////
   // state
   reg [9:0]  byte_address_q;
   reg [7:0]  byte_data_q;
   reg [1:0]  prog_mode_field_q;
   reg        ready_irq_enable_q;
   reg        master_write_arm_q;
   reg [2:0]  arm_cnt_q;
   reg        write_strobe_q;
   reg [14:0] osc_cnt_q;
   reg [2:0]  stall_cnt_q;
   reg        read_pend_q;
   reg        tick_s1_q;
   reg        tick_s2_q;
   reg        tick_s3_q;

   wire       wr_ctl;
   wire       wr_dat;
   wire       wr_lo;
   wire       wr_hi;
   wire       osc_edge;
   wire       write_done;
   wire       start_wr;
   wire       start_rd;

   ////////////////////////////////////////////////////////////////////////
   // one offset compare shared by write decode and read mux
   function reg_hit;
      input [5:0] addr;
      input [5:0] ofs;
      begin
         reg_hit = (addr == ofs);
      end
   endfunction

   // saturating step down, shared by arm timer and stall counter
   function [2:0] count_down;
      input [2:0] cnt;
      begin
         if (cnt != 3'h0) begin
            count_down = cnt - 3'h1;
         end else begin
            count_down = 3'h0;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // write decode
   assign wr_ctl = io_wr && reg_hit(io_addr, `OFS_CONTROL);
   assign wr_dat = io_wr && reg_hit(io_addr, `OFS_DATA);
   assign wr_lo  = io_wr && reg_hit(io_addr, `OFS_ADDR_LOW);
   assign wr_hi  = io_wr && reg_hit(io_addr, `OFS_ADDR_HIGH);

   // strobe accepted only when armed, idle and flash not writing
   assign start_wr = rst_n && wr_ctl
                     && io_wdata[`BIT_WRITE_STROBE]
                     && master_write_arm_q
                     && !write_strobe_q
                     && !flash_prog_busy;
   assign start_rd = rst_n && wr_ctl
                     && io_wdata[`BIT_READ_STROBE]
                     && !write_strobe_q;

   ////////////////////////////////////////////////////////////////////////
   // rc oscillator tick synchroniser; first stage feeds only the second
   always @(posedge ref_clk) begin
      tick_s1_q <= rc_osc_tick;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
   end

   assign osc_edge   = tick_s2_q && !tick_s3_q;
   assign write_done = osc_edge
                       && (osc_cnt_q == WRITE_LEN - 15'h0001);

   ////////////////////////////////////////////////////////////////////////
   // write engine ignores reset while busy so a running write finishes;
   // idle branch last so an unknown power-up strobe falls into it
   always @(posedge ref_clk) begin
      if (start_wr) begin
         write_strobe_q <= 1'b1;
         osc_cnt_q      <= 15'h0000;
         mem_write      <= 1'b1;
      end else if (write_strobe_q) begin
         mem_write <= 1'b0;
         if (write_done) begin
            write_strobe_q <= 1'b0;
         end else if (osc_edge) begin
            osc_cnt_q <= osc_cnt_q + 15'h0001;
         end
      end else begin
         write_strobe_q <= 1'b0;
         osc_cnt_q      <= 15'h0000;
         mem_write      <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mode field held through reset while busy
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         if (write_strobe_q) begin
            prog_mode_field_q <= prog_mode_field_q;
         end else begin
            prog_mode_field_q <= `MODE_RESET;
         end
      end else if (wr_ctl && !write_strobe_q) begin
         prog_mode_field_q <= io_wdata[`BIT_MODE_HI:`BIT_MODE_LO];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // address register, frozen during a write
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         byte_address_q <= 10'h000;
      end else if (!write_strobe_q) begin
         if (wr_lo) begin
            byte_address_q[7:0] <= io_wdata;
         end
         if (wr_hi) begin
            byte_address_q[9:8] <= io_wdata[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // data register; fetched byte wins over a cpu write in the same cycle
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         byte_data_q <= 8'h00;
      end else if (read_pend_q) begin
         byte_data_q <= mem_rdata;
      end else if (wr_dat) begin
         byte_data_q <= io_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // ready interrupt enable
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         ready_irq_enable_q <= 1'b0;
      end else if (wr_ctl) begin
         ready_irq_enable_q <= io_wdata[`BIT_READY_IRQ];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // master write arm; a fresh arm write beats its own timeout
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         master_write_arm_q <= 1'b0;
         arm_cnt_q          <= 3'h0;
      end else if (wr_ctl && io_wdata[`BIT_MASTER_ARM]) begin
         master_write_arm_q <= 1'b1;
         arm_cnt_q          <= `ARM_CYCLES;
      end else if (start_wr) begin
         master_write_arm_q <= 1'b0;
         arm_cnt_q          <= 3'h0;
      end else if (master_write_arm_q) begin
         if (arm_cnt_q == 3'h1) begin
            master_write_arm_q <= 1'b0;
         end
         arm_cnt_q <= count_down(arm_cnt_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // cpu stall counter
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         stall_cnt_q <= 3'h0;
      end else if (start_wr) begin
         stall_cnt_q <= `WRITE_STALL;
      end else if (start_rd) begin
         stall_cnt_q <= `READ_STALL;
      end else begin
         stall_cnt_q <= count_down(stall_cnt_q);
      end
   end

   assign cpu_stall = (stall_cnt_q != 3'h0);

   ////////////////////////////////////////////////////////////////////////
   // read pulse; byte lands one cycle later, inside the stall
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         mem_read    <= 1'b0;
         read_pend_q <= 1'b0;
      end else begin
         mem_read    <= start_rd;
         read_pend_q <= start_rd;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // array port; held through reset while a write is running
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         if (write_strobe_q) begin
            mem_addr  <= mem_addr;
            mem_wdata <= mem_wdata;
            mem_mode  <= mem_mode;
         end else begin
            mem_addr  <= 10'h000;
            mem_wdata <= 8'h00;
            mem_mode  <= `MODE_RESET;
         end
      end else if (start_wr) begin
         mem_addr  <= byte_address_q;
         mem_wdata <= byte_data_q;
         mem_mode  <= prog_mode_field_q;
      end else if (start_rd) begin
         mem_addr  <= byte_address_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // level interrupt; busy flash or write holds it off
   assign ready_irq = ready_irq_enable_q
                      && global_irq_enable
                      && !write_strobe_q
                      && !flash_prog_busy;

   ////////////////////////////////////////////////////////////////////////
   // read mux; unmapped offsets read zero
   always @* begin
      io_rdata = 8'h00;
      if (io_rd && reg_hit(io_addr, `OFS_CONTROL)) begin
         io_rdata = {2'b00,
                     prog_mode_field_q,
                     ready_irq_enable_q,
                     master_write_arm_q,
                     write_strobe_q,
                     1'b0};
      end else if (io_rd && reg_hit(io_addr, `OFS_DATA)) begin
         io_rdata = byte_data_q;
      end else if (io_rd && reg_hit(io_addr, `OFS_ADDR_LOW)) begin
         io_rdata = byte_address_q[7:0];
      end else if (io_rd && reg_hit(io_addr, `OFS_ADDR_HIGH)) begin
         io_rdata = {6'b000000, byte_address_q[9:8]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // limitations
   // mode only tags the array operation; all modes share one write time
   // read strobe is never stored, so it always reads back as zero
   // address clears on reset; software must still load it before use
endmodule

/* rtl/nv_access_regs.vh */
// register offsets, field positions and timing counts for the eeprom access block
`ifndef NV_ACCESS_REGS_VH
`define NV_ACCESS_REGS_VH
`define OFS_CONTROL      6'h1F
`define OFS_DATA         6'h20
`define OFS_ADDR_LOW     6'h21
`define OFS_ADDR_HIGH    6'h22
`define BIT_READ_STROBE  0
`define BIT_WRITE_STROBE 1
`define BIT_MASTER_ARM   2
`define BIT_READY_IRQ    3
`define BIT_MODE_LO      4
`define BIT_MODE_HI      5
`define MODE_RESET       2'h0
`define MODE_ERASE_WRITE 2'h0
`define MODE_ERASE_ONLY  2'h1
`define MODE_WRITE_ONLY  2'h2
`define MODE_RESERVED    2'h3
`define ARM_CYCLES       3'h4
`define WRITE_STALL      3'h2
`define READ_STALL       3'h4
`define WRITE_OSC_CYCLES 26368
`define WRITE_TIME_US    3300
`endif

/* sim/nv_access_checker.sv */
// port-level assertions for the eeprom access control block
`timescale 1ns/1ps
module nv_access_checker (
   input wire       ref_clk,
   input wire       rst_n,
   input wire [5:0] io_addr,
   input wire       io_wr,
   input wire       io_rd,
   input wire [7:0] io_wdata,
   input wire [7:0] io_rdata,
   input wire       global_irq_enable,
   input wire       flash_prog_busy,
   input wire       cpu_stall,
   input wire       ready_irq,
   input wire       mem_write,
   input wire       mem_read
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   wr_stall_len_a: assert property (mem_write |-> cpu_stall ##1 cpu_stall
      ##1 !cpu_stall) else $error("write stall length wrong");
   rd_stall_len_a: assert property (mem_read |-> cpu_stall[*4]
      ##1 !cpu_stall) else $error("read stall length wrong");
   wr_cause_a: assert property (mem_write |-> $past(io_wr &&
      io_addr == 6'h1F && io_wdata[1] && !flash_prog_busy))
      else $error("write pulse without strobe");
   rd_cause_a: assert property (mem_read |-> $past(io_wr &&
      io_addr == 6'h1F && io_wdata[0])) else $error("read without strobe");
   irq_gate_a: assert property (ready_irq |-> global_irq_enable
      && !flash_prog_busy) else $error("irq without enables");
   irq_busy_a: assert property (mem_write |-> !ready_irq ##1
      !ready_irq) else $error("irq during write");
   ctl_rsvd_a: assert property (io_rd && io_addr == 6'h1F |->
      io_rdata[7:6] == 2'h0) else $error("control top bits set");
   addr_rsvd_a: assert property (io_rd && io_addr == 6'h22 |->
      io_rdata[7:2] == 6'h00) else $error("address top bits set");
   rd_strobe_a: assert property (io_rd && io_addr == 6'h1F |->
      !io_rdata[0]) else $error("read strobe reads one");
endmodule
bind eeprom_byte_access_ctrl nv_access_checker u_chk (.ref_clk(ref_clk),
   .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
   .io_wdata(io_wdata), .io_rdata(io_rdata), .cpu_stall(cpu_stall),
   .global_irq_enable(global_irq_enable), .ready_irq(ready_irq),
   .flash_prog_busy(flash_prog_busy), .mem_write(mem_write),
   .mem_read(mem_read));

/* sim/tb_eeprom_byte_access_ctrl.sv */
// self-checking bench for the eeprom access control block
`timescale 1ns/1ps
module tb_eeprom_byte_access_ctrl;
   logic ref_clk = 0, rst_n = 0, io_wr = 0, io_rd = 0, poll = 0;
   logic global_irq_enable = 0, flash_prog_busy = 0, rc_osc_tick = 0;
   logic [5:0] io_addr = 0;
   logic [7:0] io_wdata = 0, io_rdata, mem_rdata = 0, mem_wdata, d;
   logic [9:0] mem_addr, a;
   logic [1:0] mem_mode;
   logic       mem_write, mem_read, cpu_stall, ready_irq;
   logic [19:0] q[$];
   int n_mismatch = 0, checks = 0, seed = 24755;
   always #10 ref_clk = ~ref_clk;
   always #70 rc_osc_tick = ~rc_osc_tick;
   // short write count keeps each write near sixty clocks
   eeprom_byte_access_ctrl #(.WRITE_OSC(8)) u_dut (.ref_clk(ref_clk),
      .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .rc_osc_tick(rc_osc_tick),
      .global_irq_enable(global_irq_enable), .cpu_stall(cpu_stall),
      .flash_prog_busy(flash_prog_busy), .ready_irq(ready_irq),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_mode(mem_mode),
      .mem_write(mem_write), .mem_read(mem_read), .mem_rdata(mem_rdata));
   ////////////////////////////////////////
   task chk(string n, logic [19:0] e, logic [19:0] v);
      checks++;
      if (e !== v) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", n, e, v);
      end
   endtask
   task io_w(logic [5:0] ad, logic [7:0] dt);
      io_wr = 1; io_rd = 0; poll = 0; io_addr = ad; io_wdata = dt;
      @(posedge ref_clk); #1;
   endtask
   task io_r(logic [5:0] ad, logic [7:0] e);
      io_wr = 0; io_rd = 1; poll = 0; io_addr = ad;
      q.push_back({12'h000, e});
      @(posedge ref_clk); #1;
   endtask
   task idle(int n);
      if (n > 0) begin
         io_wr = 0; io_rd = 0; poll = 0;
         repeat (n) @(posedge ref_clk);
         #1;
      end
   endtask
   task wait_done;
      io_wr = 0; io_rd = 1; poll = 1; io_addr = 6'h1F; #1;
      for (int i = 0; i < 400 && io_rdata[1] !== 1'b0; i++) begin
         @(posedge ref_clk); #1;
      end
      chk("write_strobe", 0, {19'h0, io_rdata[1]});
   endtask
   task results;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // polls bypass the queue: their count depends on write time
   always @(posedge ref_clk) if (rst_n && ((io_rd && !poll) || mem_write))
      if (mem_write) chk("mem", q.pop_front(), {mem_mode, mem_addr, mem_wdata});
      else chk("io_rdata", q.pop_front(), {12'h000, io_rdata});
   initial begin
      #200000 n_mismatch++;
      results;
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      #1 rst_n = 1;
      io_r(6'h1F, 8'h00);
      io_r(6'h20, 8'h00);
      $display("reset test done");
      for (int m = 0; m < 3; m++) begin
         a = $random(seed); d = $random(seed); mem_rdata = $random(seed);
         io_w(6'h22, {6'h00, a[9:8]}); io_w(6'h21, a[7:0]); io_w(6'h20, d);
         io_r(6'h22, {6'h00, a[9:8]});
         io_w(6'h1F, {2'h0, m[1:0], 4'h4});
         q.push_back({m[1:0], a, d});
         idle(m + m / 2);
         io_w(6'h1F, {2'h0, m[1:0], 4'h2});
         idle(3);
         io_w(6'h21, ~a[7:0]);
         io_w(6'h1F, 8'h31);
         wait_done;
         io_r(6'h1F, {2'h0, m[1:0], 4'h0});
         io_r(6'h21, a[7:0]);
         io_r(6'h20, d);
      end
      $display("write test done");
      io_w(6'h1F, 8'h02); idle(2);
      io_w(6'h1F, 8'h04); idle(5); io_w(6'h1F, 8'h02); idle(2);
      flash_prog_busy = 1;
      io_w(6'h1F, 8'h04); io_w(6'h1F, 8'h02); idle(3);
      flash_prog_busy = 0;
      io_r(6'h1F, 8'h00);
      d = $random(seed); mem_rdata = d;
      io_w(6'h1F, 8'h01); idle(5);
      io_r(6'h20, d);
      io_r(6'h1F, 8'h00);
      $display("read test done");
      io_w(6'h1F, 8'h08); global_irq_enable = 1; idle(1);
      chk("ready_irq", 1, {19'h0, ready_irq});
      flash_prog_busy = 1; idle(1);
      chk("ready_irq", 0, {19'h0, ready_irq});
      flash_prog_busy = 0; global_irq_enable = 0; idle(1);
      chk("ready_irq", 0, {19'h0, ready_irq});
      $display("irq test done");
      // reset in mid-write: write finishes, mode survives
      io_w(6'h22, 8'h00);
      io_w(6'h1F, 8'h14); io_w(6'h1F, 8'h12);
      q.push_back({2'h1, 2'h0, a[7:0], d});
      idle(2); rst_n = 0; idle(2); rst_n = 1;
      wait_done;
      io_r(6'h1F, 8'h10);
      $display("mid-write reset test done");
      results;
   end
endmodule
